// [common/edge_counter_pkg.sv]
// Operation
// [RL1] Up mode adds one to the current value per count-up rising edge.
// [RL2] Up block output is high while current value is at or above preset.
// [RL3] Up block wipe clears the current value and drops its output.
// [RL4] Up counting halts once the current value reaches the preset.
// [RL5] Down mode subtracts one, starting from preset, per count-down rising edge.
// [RL6] Down block output is high while current value equals zero.
// [RL7] Down block load resets it and copies the preset into the current value.
// [RL8] Down counting halts once the current value reaches zero.
// [RL9] Bidirectional block counts up on up edges, down on down edges; the code counts neither when both edges come in one scan.
// [RL10] Bidirectional upper-limit output is high while current value equals preset.
// [RL11] Bidirectional zero-reached output is high while current value equals zero.
// [RL12] Bidirectional load copies the preset into the current value.
// [RL13] Bidirectional wipe resets it and sets the current value to zero.
// [RL14] Bidirectional counting saturates at preset going up and zero going down.
// [RL15] Program must not give one counter number to two counter blocks.
// [RL16] Values are 16-bit signed; outputs are evaluated once per scan clock.
package edge_counter_pkg;
	localparam int VALUE_WIDTH = 16;
	localparam logic signed [15:0] VALUE_ZERO = 16'sh0000;
	localparam logic signed [15:0] VALUE_ONE = 16'sh0001;

	// Counting behaviour of the block bound to a counter number
	typedef enum logic [2:0] {
		MODE_UP = 3'h1,
		MODE_DOWN = 3'h2,
		MODE_BIDIR = 3'h4
	} count_mode_t;

	// Controls the program drives into the block
	typedef struct packed {
		logic count_up_input;
		logic count_down_input;
		logic preset_load_input;
		logic wipe_input;
		logic signed [15:0] preset_value;
	} counter_ctrl_t;

	// Results the program reads back
	typedef struct packed {
		logic signed [15:0] current_value;
		logic upper_limit_output;
		logic zero_reached_output;
	} counter_stat_t;
endpackage : edge_counter_pkg

// [logic/rise_detect.sv]
`timescale 1ns/1ps
// Rising edge detector for the count inputs
module rise_detect (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Level in, pulse out
	input wire logic i_level,
	output logic o_rise
);
	logic prev_q;

	// Previous sample; reset low so a level high at release counts once
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= i_level;
		end
	end

	assign o_rise = i_level & ~prev_q;
endmodule : rise_detect

// [logic/edge_counter_blocks.sv]
`timescale 1ns/1ps
// Shared current value driven by up, down or bidirectional counter block
module edge_counter_blocks (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Block selection and program controls
	input wire edge_counter_pkg::count_mode_t i_mode,
	input wire edge_counter_pkg::counter_ctrl_t i_ctrl,
	// Counter results
	output edge_counter_pkg::counter_stat_t o_stat
);
	logic signed [15:0] cv_q;
	logic signed [15:0] cv_d;
	logic up_q;
	logic zero_q;
	logic up_d;
	logic zero_d;
	logic up_rise;
	logic down_rise;

	// Edge detectors, bit 0 for count-up and bit 1 for count-down
	wire [1:0] count_level = {i_ctrl.count_down_input, i_ctrl.count_up_input};
	wire [1:0] count_rise;
	for (genvar g = 0; g < 2; g++) begin : g_edge
		rise_detect u_edge (
			.i_clock(i_clock),
			.i_rst(i_rst),
			.i_level(count_level[g]),
			.o_rise(count_rise[g])
		);
	end
	assign up_rise = count_rise[0];
	assign down_rise = count_rise[1];

	// Mode and saturation decode
	wire is_up = (i_mode == edge_counter_pkg::MODE_UP);
	wire is_down = (i_mode == edge_counter_pkg::MODE_DOWN);
	wire is_bidir = (i_mode == edge_counter_pkg::MODE_BIDIR);
	wire signed [15:0] pv = i_ctrl.preset_value;
	wire at_preset = (cv_q >= pv);
	wire at_zero = (cv_q <= edge_counter_pkg::VALUE_ZERO);
	wire signed [15:0] cv_inc = cv_q + edge_counter_pkg::VALUE_ONE;
	wire signed [15:0] cv_dec = cv_q - edge_counter_pkg::VALUE_ONE;
	wire do_inc = up_rise & ~at_preset & (is_up | (is_bidir & ~down_rise)); // RL4 RL14
	wire do_dec = down_rise & ~at_zero & (is_down | (is_bidir & ~up_rise)); // RL8 RL14

	// Wipe reaches up and bidirectional blocks only, load down and bidirectional only
	wire wipe_hit = (is_up | is_bidir) & i_ctrl.wipe_input;
	wire load_hit = (is_down | is_bidir) & i_ctrl.preset_load_input;

	// Zero compare shared by both zero flags
	function automatic logic value_is_zero(
		input logic signed [edge_counter_pkg::VALUE_WIDTH-1:0] v);
		return (v == edge_counter_pkg::VALUE_ZERO);
	endfunction : value_is_zero

	// Next current value; wipe beats load, both beat counting
	always_comb begin
		cv_d = cv_q;
		if (wipe_hit) begin
			cv_d = edge_counter_pkg::VALUE_ZERO; // RL3 RL13
		end else if (load_hit) begin
			cv_d = pv; // RL7 RL12
		end else if (do_inc) begin
			cv_d = cv_inc; // RL1 RL9
		end else if (do_dec) begin
			cv_d = cv_dec; // RL5 RL9
		end
	end

	// Output bits follow the new value, one evaluation per scan clock
	always_comb begin
		up_d = 1'b0;
		zero_d = 1'b0;
		if (is_up) begin
			up_d = (cv_d >= pv) & ~i_ctrl.wipe_input; // RL2 RL3
		end else if (is_down) begin
			zero_d = value_is_zero(cv_d); // RL6
		end else if (is_bidir) begin
			up_d = (cv_d == pv); // RL10
			zero_d = value_is_zero(cv_d); // RL11
		end
	end

	// Single store per counter number, so block types cannot clash
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			cv_q <= edge_counter_pkg::VALUE_ZERO;
			up_q <= 1'b0;
			zero_q <= 1'b0;
		end else begin
			cv_q <= cv_d; // RL16
			up_q <= up_d;
			zero_q <= zero_d;
		end
	end

	assign o_stat.current_value = cv_q;
	assign o_stat.upper_limit_output = up_q;
	assign o_stat.zero_reached_output = zero_q;

	// Checks
	sequence s_up_edge_free;
		!i_rst && is_up && up_rise && !i_ctrl.wipe_input && !at_preset;
	endsequence

	a_up_increment: assert property (@(posedge i_clock) disable iff (i_rst) // RL1
		s_up_edge_free |=> (cv_q == $past(cv_q) + 16'sh0001))
		else $error("up edge did not add one");
	// Flags on the first edge after reset come from reset, so compares skip it
	a_up_output: assert property (@(posedge i_clock) disable iff (i_rst) // RL2
		!$past(i_rst) && $past(is_up) && $stable(pv) && !$past(i_ctrl.wipe_input)
		|-> (up_q == (cv_q >= pv)))
		else $error("up output disagrees with compare");
	a_up_wipe: assert property (@(posedge i_clock) disable iff (i_rst) // RL3
		(is_up && i_ctrl.wipe_input) |=> (cv_q == 16'sh0000) && !up_q)
		else $error("wipe did not clear up block");
	a_up_hold: assert property (@(posedge i_clock) disable iff (i_rst) // RL4
		(is_up && !i_ctrl.wipe_input && at_preset) |=> $stable(cv_q))
		else $error("up block counted past preset");
	a_down_dec: assert property (@(posedge i_clock) disable iff (i_rst) // RL5
		(is_down && down_rise && !i_ctrl.preset_load_input && !at_zero)
		|=> (cv_q == $past(cv_q) - 16'sh0001))
		else $error("down edge did not subtract one");
	a_down_zero: assert property (@(posedge i_clock) disable iff (i_rst) // RL6
		!$past(i_rst) && $past(is_down) |-> (zero_q == (cv_q == 16'sh0000)))
		else $error("down output disagrees with zero");
	a_down_load: assert property (@(posedge i_clock) disable iff (i_rst) // RL7
		(is_down && i_ctrl.preset_load_input) |=> (cv_q == $past(pv)))
		else $error("load did not copy preset");
	a_down_hold: assert property (@(posedge i_clock) disable iff (i_rst) // RL8
		(is_down && !i_ctrl.preset_load_input && at_zero) |=> $stable(cv_q))
		else $error("down block counted below zero");
	a_bidir_step: assert property (@(posedge i_clock) disable iff (i_rst) // RL9
		(is_bidir && !i_ctrl.wipe_input && !i_ctrl.preset_load_input
		&& down_rise && !up_rise && !at_zero) |=> (cv_q == $past(cv_q) - 16'sh0001))
		else $error("bidirectional down step wrong");
	a_bidir_limits: assert property (@(posedge i_clock) disable iff (i_rst) // RL10
		!$past(i_rst) && $past(is_bidir) && $stable(pv) |-> (up_q == (cv_q == pv))
		&& (zero_q == (cv_q == 16'sh0000)))
		else $error("bidirectional flags wrong");
	a_bidir_wipe: assert property (@(posedge i_clock) disable iff (i_rst) // RL13
		(is_bidir && i_ctrl.wipe_input) |=> (cv_q == 16'sh0000) && zero_q)
		else $error("bidirectional wipe failed");
	a_bidir_sat: assert property (@(posedge i_clock) disable iff (i_rst) // RL14
		(is_bidir && !i_ctrl.wipe_input && !i_ctrl.preset_load_input && at_preset
		&& !down_rise) |=> $stable(cv_q))
		else $error("bidirectional passed preset");

	// Further steps of the counting behaviour
	sequence s_bidir_up_free;
		is_bidir && !i_ctrl.wipe_input && !i_ctrl.preset_load_input
		&& up_rise && !down_rise && !at_preset;
	endsequence

	sequence s_bidir_floor;
		is_bidir && !i_ctrl.wipe_input && !i_ctrl.preset_load_input
		&& at_zero && !up_rise;
	endsequence

	sequence s_no_block;
		!is_up && !is_down && !is_bidir;
	endsequence

	// Bidirectional block: load, up step, clash of edges, floor and range
	a_bidir_load: assert property (@(posedge i_clock) disable iff (i_rst) // RL12
		(is_bidir && !i_ctrl.wipe_input && i_ctrl.preset_load_input)
		|=> (cv_q == $past(pv)))
		else $error("bidirectional load did not copy preset");
	a_bidir_rise: assert property (@(posedge i_clock) disable iff (i_rst) // RL9
		s_bidir_up_free |=> (cv_q == $past(cv_q) + 16'sh0001))
		else $error("bidirectional up step wrong");
	a_bidir_clash: assert property (@(posedge i_clock) disable iff (i_rst) // RL9
		(is_bidir && !i_ctrl.wipe_input && !i_ctrl.preset_load_input
		&& up_rise && down_rise) |=> $stable(cv_q))
		else $error("bidirectional counted on both edges");
	a_bidir_floor: assert property (@(posedge i_clock) disable iff (i_rst) // RL14
		s_bidir_floor |=> $stable(cv_q))
		else $error("bidirectional passed zero");
	a_bidir_range: assert property (@(posedge i_clock) disable iff (i_rst) // RL14
		(is_bidir && !i_ctrl.wipe_input && !i_ctrl.preset_load_input
		&& (cv_q >= 16'sh0000) && (cv_q <= pv))
		|=> (cv_q >= 16'sh0000) && (cv_q <= $past(pv)))
		else $error("bidirectional value left its range");

	// Up block: one count per edge, load ignored, never past preset
	a_up_edge_once: assert property (@(posedge i_clock) disable iff (i_rst) // RL1
		(!$past(i_rst) && is_up && $past(i_ctrl.count_up_input) && !i_ctrl.wipe_input)
		|=> $stable(cv_q))
		else $error("up block counted a held level");
	a_up_no_load: assert property (@(posedge i_clock) disable iff (i_rst) // RL1
		(is_up && i_ctrl.preset_load_input && !i_ctrl.wipe_input && !up_rise)
		|=> $stable(cv_q))
		else $error("up block took a load");
	a_up_ceiling: assert property (@(posedge i_clock) disable iff (i_rst) // RL4
		(is_up && !i_ctrl.wipe_input && (cv_q < pv)) |=> (cv_q <= $past(pv)))
		else $error("up block stepped over preset");
	a_up_only_flag: assert property (@(posedge i_clock) disable iff (i_rst) // RL2
		$past(is_up) |-> !zero_q)
		else $error("up block raised the zero flag");

	// Down block: one count per edge, wipe ignored, never below zero
	a_down_edge_once: assert property (@(posedge i_clock) disable iff (i_rst) // RL5
		(!$past(i_rst) && is_down && $past(i_ctrl.count_down_input)
		&& !i_ctrl.preset_load_input) |=> $stable(cv_q))
		else $error("down block counted a held level");
	a_down_no_wipe: assert property (@(posedge i_clock) disable iff (i_rst) // RL7
		(is_down && i_ctrl.wipe_input && !i_ctrl.preset_load_input && !down_rise)
		|=> $stable(cv_q))
		else $error("down block took a wipe");
	a_down_floor: assert property (@(posedge i_clock) disable iff (i_rst) // RL8
		(is_down && !i_ctrl.preset_load_input && (cv_q > 16'sh0000)) |=> (cv_q >= 16'sh0000))
		else $error("down block went below zero");
	a_zero_value: assert property (@(posedge i_clock) disable iff (i_rst) // RL6
		zero_q |-> (cv_q == 16'sh0000))
		else $error("zero flag with nonzero value");

	// No block selected keeps the shared value; reset clears everything
	a_mode_idle: assert property (@(posedge i_clock) disable iff (i_rst) // RL16
		s_no_block |=> $stable(cv_q) && !up_q && !zero_q)
		else $error("unselected block changed state");
	a_reset_clear: assert property (@(posedge i_clock) // RL16
		i_rst |=> (cv_q == 16'sh0000) && !up_q && !zero_q)
		else $error("reset left state behind");
endmodule : edge_counter_blocks

// [tb/prog_model.sv]
`timescale 1ns/1ps
// Stand-in for the control program; registers one scan's controls
module prog_model (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Scan request: up, down, load, wipe levels and preset
	input wire logic [3:0] i_bits,
	input wire logic signed [15:0] i_preset,
	// Controls toward the counter
	output edge_counter_pkg::counter_ctrl_t o_ctrl
);
	// One control set per counter number, shared by whichever block the mode selects
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_ctrl <= '0;
		end else begin
			o_ctrl <= {i_bits, i_preset};
		end
	end
endmodule : prog_model

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic i_clock;
	logic i_rst;
	edge_counter_pkg::count_mode_t mode;
	logic [3:0] bits;
	logic signed [15:0] preset;
	edge_counter_pkg::counter_ctrl_t ctrl;
	edge_counter_pkg::counter_stat_t o_stat;
	edge_counter_pkg::counter_stat_t exp_q;
	logic pu;
	logic pd;
	logic [31:0] rnd;
	int n_errors;
	int tests_run;
	// Modes with presets; 3 is an unused code, FFFB a negative preset
	logic [2:0] t_mode [6] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h3, 3'h4};
	logic signed [15:0] t_pre [6] = '{16'sh0005, 16'sh0003, 16'shFFFB, 16'sh0004,
		16'sh0002, 16'sh0001};
	prog_model u_prog (.i_clock(i_clock), .i_rst(i_rst), .i_bits(bits), .i_preset(preset),
		.o_ctrl(ctrl));
	edge_counter_blocks u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_mode(mode), .i_ctrl(ctrl),
		.o_stat(o_stat));
	// Free-running scan clock
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	// Next result from sampled controls; edges need a low sample before
	function automatic edge_counter_pkg::counter_stat_t step(
		input edge_counter_pkg::count_mode_t m, input edge_counter_pkg::counter_ctrl_t c,
		input logic pu, input logic pd, input logic signed [15:0] v);
		logic um;
		logic dm;
		logic bm;
		logic eu;
		logic ed;
		edge_counter_pkg::counter_stat_t s;
		um = (m == edge_counter_pkg::MODE_UP);
		dm = (m == edge_counter_pkg::MODE_DOWN);
		bm = (m == edge_counter_pkg::MODE_BIDIR);
		eu = c.count_up_input & ~pu & (um | bm) & ~(bm & c.count_down_input & ~pd);
		ed = c.count_down_input & ~pd & (dm | bm) & ~(bm & c.count_up_input & ~pu);
		if (c.wipe_input && (um || bm)) v = 16'sh0000;
		else if (c.preset_load_input && (dm || bm)) v = c.preset_value;
		else if (eu && v < c.preset_value) v = v + 16'sh0001;
		else if (ed && v > 16'sh0000) v = v - 16'sh0001;
		s.current_value = v;
		s.upper_limit_output = (um && v >= c.preset_value && !c.wipe_input) ||
			(bm && v == c.preset_value);
		s.zero_reached_output = (dm || bm) && v == 16'sh0000;
		return s;
	endfunction : step
	task automatic check(input edge_counter_pkg::counter_stat_t seen,
		input edge_counter_pkg::counter_stat_t want);
		tests_run++;
		if (seen !== want) begin
			n_errors++;
			$display("BAD %0t stat %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	// Random levels each scan; a load opens every test, a wipe lands mid-test
	initial begin
		i_rst = 1'b1;
		mode = edge_counter_pkg::MODE_UP;
		bits = 4'h0;
		preset = 16'sh0000;
		exp_q = '0;
		pu = 1'b0;
		pd = 1'b0;
		rnd = 32'h00018066;
		n_errors = 0;
		tests_run = 0;
		repeat (5) @(posedge i_clock);
		i_rst <= 1'b0;
		for (int t = 0; t < 6; t++) begin
			for (int k = 0; k < 40; k++) begin
				@(posedge i_clock);
				exp_q = step(mode, ctrl, pu, pd, exp_q.current_value);
				pu = ctrl.count_up_input;
				pd = ctrl.count_down_input;
				rnd = lfsr(rnd);
				mode <= edge_counter_pkg::count_mode_t'(t_mode[t]);
				preset <= t_pre[t];
				bits <= (k == 0) ? 4'h2 : (k == 20) ? 4'h1 :
					{rnd[1:0], rnd[6:2] == 5'h1F, rnd[11:7] == 5'h1F};
				#1 check(o_stat, exp_q);
			end
			$display("Test %0d done, mode %0h", t, t_mode[t]);
		end
		wrap_up();
	end
endmodule : testbench
